// file: rtl/msc_loader.sv
`timescale 1ns/1ps
`include "msc_map.svh"
module msc_loader import msc_pkg::*; (
  input  wire logic       clk,               // System clock
  input  wire logic       rst,               // Synchronous reset
  input  wire logic       oscClk,            // Internal oscillator
  input  wire logic       programRequestN,   // Restart request pin
  input  wire logic [2:0] modeSelectPins,    // Mode select pins
  input  wire logic       pullupDisablePin,  // Pull-up control pin
  input  wire logic       serialConfigIn,    // Serial data in
  output logic            configClockOut,    // Configuration clock
  output logic            configClockOe,     // Clock pin drive
  output logic            serialConfigOut,   // Serial data out
  output logic            serialConfigOutOe, // Data out pin drive
  input  wire logic       initStatusNIn,     // Init line level
  output logic            initStatusNOut,    // Init drive value
  output logic            initStatusNOe,     // Init pull low
  input  wire logic       doneIn,            // Done line level
  output logic            doneOut,           // Done drive value
  output logic            doneOe,            // Done pull low
  output logic            userPullupEn,      // User pull-ups on
  output logic            userIoRelease,     // Dual pins to user
  output logic [7:0]      cfgData,           // Payload byte
  output logic            cfgValid,          // Payload valid
  input  wire logic       cfgReady,          // Payload accepted
  output logic            configDone,        // Load finished
  output logic            crcError,          // Checksum failed
  output logic            modeError          // Unsupported mode
);
  localparam logic [5:0] PROG_CYC = 6'(`MSC_PROG_CYC);
  localparam logic [7:0] CLR_CYC  = 8'(`MSC_CLEAR_CYC);

  msc_core_st_t r;
  msc_core_st_t next_r;
  logic         bufInValid;
  logic         bufInReady;
  logic         bufOutValid;
  logic         bufOutReady;
  logic [7:0]   bufOutData;
  logic         pop;

  msc_link_if lk ();

  // One step of the payload checksum
  function automatic logic [7:0] crcStep(input logic [7:0] c,
                                         input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++)
      x = x[7] ? ((x << 1) ^ `MSC_CRC_POLY) : (x << 1);
    crcStep = x;
  endfunction

  // Clock-side shifter on the oscillator
  msc_link u_link (
    .oscClk          (oscClk),
    .rst             (rst),
    .lk              (lk.link),
    .serialConfigIn  (serialConfigIn),
    .configClockOut  (configClockOut),
    .serialConfigOut (serialConfigOut)
  );

  // Two-entry buffer between crossing and parser
  msc_buf #(
    .W (8),
    .D (2)
  ) u_buf (
    .clk      (clk),
    .rst      (rst),
    .flush    (!r.run),
    .inValid  (bufInValid),
    .inReady  (bufInReady),
    .inData   (lk.byteData),
    .outValid (bufOutValid),
    .outReady (bufOutReady),
    .outData  (bufOutData)
  );

  // Crossing controls toward the shifter
  assign lk.run     = r.run;
  assign lk.fwd     = r.fwd;
  assign lk.rateTog = r.rateTog;
  assign lk.rateSel = r.rateSel;
  assign lk.ackTog  = r.ackTog;

  // Open-drain lines only ever pull low
  assign initStatusNOut = 1'b0;
  assign doneOut        = 1'b0;
  assign initStatusNOe = (r.state == ST_CLEAR) || (r.state == ST_PROG) ||
                         (r.state == ST_CRC_ERR);
  assign doneOe = (r.state != ST_CHAIN) && (r.state != ST_DONE);
  assign configClockOe     = (r.state != ST_DONE);
  assign serialConfigOutOe = (r.state != ST_DONE);
  assign userPullupEn  = (r.state != ST_DONE) && !r.pullupDis;
  assign userIoRelease = (r.state == ST_DONE);
  assign configDone    = (r.state == ST_DONE);
  assign crcError      = (r.state == ST_CRC_ERR);
  assign modeError     = (r.state == ST_BAD_MODE);
  assign cfgData       = r.cfgData;
  assign cfgValid      = r.cfgValid;

  // Payload handoff needs the output slot free
  assign pop = bufOutValid && (!r.cfgValid || cfgReady);

  // Sequencer, pin sampling and restart detection
  always_comb begin
    next_r = r;
    bufInValid  = 1'b0;
    bufOutReady = 1'b0;
    next_r.progS = {r.progS[0], programRequestN};
    next_r.initS = {r.initS[0], initStatusNIn};
    next_r.doneS = {r.doneS[0], doneIn};
    next_r.pullS = {r.pullS[0], pullupDisablePin};
    next_r.modeS = {r.modeS[0], modeSelectPins};
    next_r.byteS = {r.byteS[0], lk.byteTog};

    // Accept finished bytes; no ack stalls the shifter
    if (!r.run) begin
      next_r.byteSeen = r.byteS[1];
      next_r.ackTog   = 1'b0;
    end else if (r.byteS[1] != r.byteSeen) begin
      bufInValid = 1'b1;
      if (bufInReady) begin
        next_r.byteSeen = r.byteS[1];
        next_r.ackTog   = r.byteS[1];
      end
    end

    if (r.cfgValid && cfgReady)
      next_r.cfgValid = 1'b0;

    case (r.state)
      ST_CLEAR: begin
        next_r.run       = 1'b0;
        next_r.fwd       = 1'b0;
        next_r.pullupDis = r.pullS[1];
        if (r.progS[1]) begin
          if (r.clrCnt == CLR_CYC - 8'h01) begin
            next_r.clrCnt = '0;
            next_r.state  = ST_WAIT_INIT;
          end else begin
            next_r.clrCnt = r.clrCnt + 8'h01;
          end
        end
      end
      ST_WAIT_INIT: begin
        next_r.pullupDis = r.pullS[1];
        if (r.initS[1]) begin
          if (r.modeS[1] == `MSC_MODE_MASTER) begin
            next_r.run     = 1'b1;
            next_r.rateSel = `MSC_RATE_SLOW;
            next_r.state   = ST_SYNC;
          end else begin
            next_r.state = ST_BAD_MODE;
          end
        end
      end
      ST_SYNC: begin
        bufOutReady = bufOutValid;
        if (bufOutValid && bufOutData == `MSC_SYNC_BYTE)
          next_r.state = ST_RATE;
      end
      ST_RATE: begin
        bufOutReady = bufOutValid;
        if (bufOutValid) begin
          next_r.rateSel = bufOutData[1:0];
          next_r.rateTog = !r.rateTog;
          next_r.state   = ST_LEN_HI;
        end
      end
      ST_LEN_HI: begin
        bufOutReady = bufOutValid;
        if (bufOutValid) begin
          next_r.len[15:8] = bufOutData;
          next_r.state     = ST_LEN_LO;
        end
      end
      ST_LEN_LO: begin
        bufOutReady = bufOutValid;
        if (bufOutValid) begin
          next_r.len[7:0] = bufOutData;
          next_r.crc      = `MSC_CRC_INIT;
          next_r.state    = ({r.len[15:8], bufOutData} == 16'h0000) ?
                            ST_CRC : ST_DATA;
        end
      end
      ST_DATA: begin
        bufOutReady = pop;
        if (pop) begin
          next_r.cfgData  = bufOutData;
          next_r.cfgValid = 1'b1;
          next_r.crc      = crcStep(r.crc, bufOutData);
          next_r.len      = r.len - 16'h0001;
          if (r.len == 16'h0001)
            next_r.state = ST_CRC;
        end
      end
      ST_CRC: begin
        bufOutReady = bufOutValid;
        if (bufOutValid) begin
          if (bufOutData == r.crc) begin
            next_r.fwd   = 1'b1;
            next_r.state = ST_CHAIN;
          end else begin
            next_r.run   = 1'b0;
            next_r.state = ST_CRC_ERR;
          end
        end
      end
      ST_CHAIN: begin
        // Later bytes belong to the next device
        bufOutReady = bufOutValid;
        if (r.doneS[1]) begin
          next_r.run   = 1'b0;
          next_r.fwd   = 1'b0;
          next_r.state = ST_DONE;
        end
      end
      ST_DONE, ST_CRC_ERR, ST_BAD_MODE, ST_PROG: begin
        next_r.run = 1'b0;
      end
      default: begin
        next_r.state = ST_CLEAR;
      end
    endcase

    if (!r.progS[1]) begin
      if (r.progCnt == PROG_CYC - 6'h01)
        next_r.progArmed = 1'b1;
      else
        next_r.progCnt = r.progCnt + 6'h01;
    end else begin
      next_r.progCnt = '0;
    end

    if (r.progArmed) begin
      next_r.state    = ST_PROG;
      next_r.run      = 1'b0;
      next_r.fwd      = 1'b0;
      next_r.cfgValid = 1'b0;
      next_r.clrCnt   = '0;
      if (r.progS[1]) begin
        next_r.progArmed = 1'b0;
        next_r.state     = ST_CLEAR;
      end
    end

    if (rst) begin
      next_r       = '0;
      next_r.state = ST_CLEAR;
      next_r.progS = 2'b11;
      next_r.initS = 2'b11;
    end
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end
endmodule // msc_loader

// file: rtl/msc_map.svh
`ifndef MSC_MAP_SVH
`define MSC_MAP_SVH

// System clock rate
`define MSC_CLK_MHZ      100
// Least restart pulse on the program request pin
`define MSC_PROG_MIN_NS  300
`define MSC_PROG_CYC     ((`MSC_PROG_MIN_NS * `MSC_CLK_MHZ + 999) / 1000)
// Time spent clearing configuration memory
`define MSC_CLEAR_NS     1000
`define MSC_CLEAR_CYC    ((`MSC_CLEAR_NS * `MSC_CLK_MHZ + 999) / 1000)
// Mode pin value for master serial loading
`define MSC_MODE_MASTER  3'h0
// Bitstream framing
`define MSC_SYNC_BYTE    8'hA5
`define MSC_CRC_POLY     8'h07
`define MSC_CRC_INIT     8'h00
// Clock rate option codes and half periods in oscillator cycles
`define MSC_RATE_SLOW    2'h0
`define MSC_HALF_R0      8'h08
`define MSC_HALF_R1      8'h04
`define MSC_HALF_R2      8'h03
`define MSC_HALF_R3      8'h02
// Idle level on the serial output
`define MSC_DOUT_IDLE    1'b1

`endif

// file: rtl/msc_pkg.sv
package msc_pkg;

  typedef enum logic [3:0] {
    ST_CLEAR     = 4'b0000,
    ST_WAIT_INIT = 4'b0001,
    ST_SYNC      = 4'b0010,
    ST_RATE      = 4'b0011,
    ST_LEN_HI    = 4'b0100,
    ST_LEN_LO    = 4'b0101,
    ST_DATA      = 4'b0110,
    ST_CRC       = 4'b0111,
    ST_CHAIN     = 4'b1000,
    ST_DONE      = 4'b1001,
    ST_CRC_ERR   = 4'b1010,
    ST_BAD_MODE  = 4'b1011,
    ST_PROG      = 4'b1100
  } msc_state_t;

  typedef struct packed {
    logic [1:0] rstS;
    logic [1:0] runS;
    logic [1:0] fwdS;
    logic [2:0] rateS;
    logic [1:0] ackS;
    logic [1:0] dinS;
    logic [7:0] half;
    logic [7:0] div;
    logic       config_clock_out;
    logic [7:0] shift;
    logic [2:0] bitCnt;
    logic       byteTog;
    logic [7:0] byteData;
    logic       dout;
  } msc_link_st_t;

  typedef struct packed {
    msc_state_t      state;
    logic [1:0]      progS;
    logic [1:0]      initS;
    logic [1:0]      doneS;
    logic [1:0]      pullS;
    logic [1:0][2:0] modeS;
    logic [1:0]      byteS;
    logic            byteSeen;
    logic            ackTog;
    logic            rateTog;
    logic [1:0]      rateSel;
    logic            run;
    logic            fwd;
    logic [5:0]      progCnt;
    logic            progArmed;
    logic [7:0]      clrCnt;
    logic            pullupDis;
    logic [15:0]     len;
    logic [7:0]      crc;
    logic [7:0]      cfgData;
    logic            cfgValid;
  } msc_core_st_t;

endpackage

// file: rtl/msc_link_if.sv
`timescale 1ns/1ps
// Crossing signals between the loader core and the clock-side shifter
interface msc_link_if;
  logic       run;
  logic       fwd;
  logic       rateTog;
  logic [1:0] rateSel;
  logic       ackTog;
  logic       byteTog;
  logic [7:0] byteData;

  modport core (output run, fwd, rateTog, rateSel, ackTog,
                input  byteTog, byteData);
  modport link (input  run, fwd, rateTog, rateSel, ackTog,
                output byteTog, byteData);
endinterface

// file: rtl/msc_buf.sv
`timescale 1ns/1ps
module msc_buf #(
  parameter int W = 8,
  parameter int D = 2
) (
  input  wire logic         clk,       // System clock
  input  wire logic         rst,       // Synchronous reset
  input  wire logic         flush,     // Drop all entries
  input  wire logic         inValid,   // Write request
  output logic              inReady,   // Room for a word
  input  wire logic [W-1:0] inData,    // Write data
  output logic              outValid,  // Word available
  input  wire logic         outReady,  // Read request
  output logic [W-1:0]      outData    // Read data
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0]       wr;
    logic [PW-1:0]       rd;
    logic [CW-1:0]       cnt;
  } msc_buf_st_t;

  msc_buf_st_t r;
  msc_buf_st_t next_r;

  // Handshake flags from fill level
  assign inReady  = (r.cnt != CW'(D));
  assign outValid = (r.cnt != '0);
  assign outData  = r.mem[r.rd];

  // Pointer and level update
  always_comb begin
    next_r = r;
    if (inValid && inReady) begin
      next_r.mem[r.wr] = inData;
      next_r.wr = (r.wr == PW'(D - 1)) ? '0 : r.wr + 1'b1;
    end
    if (outValid && outReady)
      next_r.rd = (r.rd == PW'(D - 1)) ? '0 : r.rd + 1'b1;
    next_r.cnt = r.cnt + CW'(inValid && inReady) - CW'(outValid && outReady);
    if (rst || flush) begin
      next_r.wr  = '0;
      next_r.rd  = '0;
      next_r.cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end
endmodule // msc_buf

// file: rtl/msc_link.sv
`timescale 1ns/1ps
`include "msc_map.svh"
module msc_link import msc_pkg::*; (
  input  wire logic oscClk,          // Internal oscillator clock
  input  wire logic rst,             // Reset from the system domain
  msc_link_if.link  lk,              // Crossing to the core
  input  wire logic serialConfigIn,  // Serial data from memory
  output logic      configClockOut,  // Generated configuration clock
  output logic      serialConfigOut  // Serial data to next device
);
  msc_link_st_t r;
  msc_link_st_t next_r;
  logic         stall;
  logic         stop;

  // Half period for a clock rate option
  function automatic logic [7:0] halfFor(input logic [1:0] sel);
    case (sel)
      2'h0:    halfFor = `MSC_HALF_R0;
      2'h1:    halfFor = `MSC_HALF_R1;
      2'h2:    halfFor = `MSC_HALF_R2;
      default: halfFor = `MSC_HALF_R3;
    endcase
  endfunction

  assign configClockOut  = r.config_clock_out;
  assign serialConfigOut = r.dout;
  assign lk.byteTog      = r.byteTog;
  assign lk.byteData     = r.byteData;

  // Shifter held before the last bit of the next byte while a finished byte waits for acceptance
  assign stall = (r.byteTog != r.ackS[1]) && (r.bitCnt == 3'h7);
  assign stop  = r.rstS[1] || !r.runS[1];

  // Clock divider and bit shifter
  always_comb begin
    next_r = r;
    next_r.rstS  = {r.rstS[0], rst};
    next_r.runS  = {r.runS[0], lk.run};
    next_r.fwdS  = {r.fwdS[0], lk.fwd};
    next_r.rateS = {r.rateS[1:0], lk.rateTog};
    next_r.ackS  = {r.ackS[0], lk.ackTog};
    next_r.dinS  = {r.dinS[0], serialConfigIn};
    if (stop && r.config_clock_out && (r.div < r.half - 8'h01)) begin
      // A started high phase runs its full length before the clock parks
      next_r.div = r.div + 8'h01;
    end else if (stop) begin
      next_r.half    = halfFor(`MSC_RATE_SLOW);
      next_r.div     = '0;
      next_r.config_clock_out    = 1'b0;
      next_r.bitCnt  = '0;
      next_r.byteTog = 1'b0;
      next_r.dout    = `MSC_DOUT_IDLE;
    end else begin
      if (r.rateS[2] != r.rateS[1])
        next_r.half = halfFor(lk.rateSel);
      if (r.div < r.half - 8'h01) begin
        next_r.div = r.div + 8'h01;
      end else if (!r.config_clock_out) begin
        if (!stall) begin
          next_r.div    = '0;
          next_r.config_clock_out   = 1'b1;
          next_r.shift  = {r.shift[6:0], r.dinS[1]};
          next_r.bitCnt = r.bitCnt + 3'h1;
          if (r.bitCnt == 3'h7) begin
            next_r.byteData = {r.shift[6:0], r.dinS[1]};
            next_r.byteTog  = !r.byteTog;
          end
        end
      end else begin
        next_r.div  = '0;
        next_r.config_clock_out = 1'b0;
        next_r.dout = r.fwdS[1] ? r.shift[0] : `MSC_DOUT_IDLE;
      end
    end
  end

  always_ff @(posedge oscClk) begin
    r <= next_r;
  end
endmodule // msc_link

// file: verif/msc_mem_model.sv
`timescale 1ns/1ps
// Serial configuration memory answering on the configuration clock
module msc_mem_model (
  input  wire logic       config_clock_out,       // Configuration clock
  input  wire logic       resetN,     // Output enable, low resets address
  input  wire logic       selectN,    // Chip enable, low active
  input  wire logic [7:0] image [32], // Stored bitstream
  output logic            initHoldN,  // Power-on hold on init line
  output logic            dataOut     // Serial data to the loader
);
  logic [7:0] addr;
  logic       lastBit = 1'b0;
  logic       sel;

  always @(posedge config_clock_out or negedge resetN) begin
    if (!resetN) begin
      addr <= 8'h00;
    end else if (!selectN) begin
      addr <= addr + 8'h01;
    end
  end

  initial begin
    initHoldN = 1'b0;
    #3000 initHoldN = 1'b1;
  end

  // one bit per rise, MSB first, inverted last bit when released
  assign sel = resetN && !selectN;
  assign #1 dataOut = sel ? image[addr[7:3]][~addr[2:0]] : !lastBit;
  always @(posedge config_clock_out) begin
    if (sel) lastBit <= dataOut;
  end
endmodule // msc_mem_model

// file: verif/msc_loader_checker.sv
`timescale 1ns/1ps
// Port-level checks of the loader
module msc_loader_checker (
  input wire logic       clk,               // System clock
  input wire logic       rst,               // Synchronous reset
  input wire logic       oscClk,            // Oscillator clock
  input wire logic       programRequestN,   // Restart request
  input wire logic       configClockOut,    // Configuration clock
  input wire logic       configClockOe,     // Clock pin drive
  input wire logic       serialConfigOut,   // Serial data out
  input wire logic       serialConfigOutOe, // Data out drive
  input wire logic       initStatusNOe,     // Init pull low
  input wire logic       doneOe,            // Done pull low
  input wire logic       userPullupEn,      // User pull-ups
  input wire logic       userIoRelease,     // Pins to user
  input wire logic [7:0] cfgData,           // Payload byte
  input wire logic       cfgValid,          // Payload valid
  input wire logic       cfgReady,          // Payload accepted
  input wire logic       configDone,        // Load finished
  input wire logic       crcError,          // Checksum failed
  input wire logic       modeError          // Unsupported mode
);
  logic [5:0] lowCnt;

  // Consecutive low samples of the request pin
  always_ff @(posedge clk) begin
    if (rst || programRequestN) lowCnt <= 6'h00;
    else if (lowCnt != 6'h3f) lowCnt <= lowCnt + 6'h01;
  end

  sequence s_long_low;
    lowCnt == 6'h28;
  endsequence
  sequence s_restart;
    initStatusNOe && doneOe && !configDone;
  endsequence
  sequence s_short_pulse;
    $rose(programRequestN) && lowCnt < 6'h19 && configDone;
  endsequence

  a_reset_init_low: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> initStatusNOe [*8]) else $error("init not held low");
  a_restart_hold: assert property (@(posedge clk) disable iff (rst)
    s_long_low |-> s_restart) else $error("restart not taken");
  a_short_ignored: assert property (@(posedge clk) disable iff (rst)
    s_short_pulse |-> configDone [*8]) else $error("short pulse acted");
  a_done_release: assert property (@(posedge clk) disable iff (rst)
    configDone |-> userIoRelease && !doneOe && !configClockOe
    && !serialConfigOutOe) else $error("pins not released");
  a_dout_driven: assert property (@(posedge clk) disable iff (rst)
    !configDone |-> serialConfigOutOe) else $error("data out undriven");
  a_crc_flag: assert property (@(posedge clk) disable iff (rst)
    crcError |-> initStatusNOe && !configDone) else $error("crc not flagged");
  a_mode_block: assert property (@(posedge clk) disable iff (rst)
    modeError |-> doneOe && !configDone) else $error("bad mode loaded");
  a_pullup_off: assert property (@(posedge clk) disable iff (rst)
    userPullupEn |-> !configDone) else $error("pull-ups after done");
  a_payload_hold: assert property (@(posedge clk) disable iff (rst)
    cfgValid && !cfgReady |=> cfgValid && $stable(cfgData))
    else $error("payload dropped");
  a_clock_half: assert property (@(posedge oscClk) disable iff (rst)
    $rose(configClockOut) |-> configClockOut [*2])
    else $error("clock high too short");
  a_forward_fall: assert property (@(posedge oscClk) disable iff (rst)
    $changed(serialConfigOut) |-> !configClockOut)
    else $error("data out changed on rise");
endmodule // msc_loader_checker

bind msc_loader msc_loader_checker chk_u (.clk, .rst, .oscClk,
  .programRequestN, .configClockOut, .configClockOe, .serialConfigOut,
  .serialConfigOutOe, .initStatusNOe, .doneOe, .userPullupEn,
  .userIoRelease, .cfgData, .cfgValid, .cfgReady, .configDone, .crcError,
  .modeError);

// file: verif/msc_loader_bench.sv
`timescale 1ns/1ps
// Self-checking bench of the master serial loader
module msc_loader_bench;
  logic       clk = 1'b0, rst = 1'b1, oscClk = 1'b0;
  logic       programRequestN = 1'b1, pullupDisablePin = 1'b0;
  logic [2:0] modeSelectPins = 3'h0;
  logic       cfgReady = 1'b0, extDoneLow = 1'b0;
  logic       configClockOut, configClockOe, serialConfigOut;
  logic       serialConfigOutOe, initStatusNOut, initStatusNOe;
  logic       doneOut, doneOe, userPullupEn, userIoRelease, cfgValid;
  logic       configDone, crcError, modeError, serialConfigIn, initHoldN;
  logic       initLine, doneLine, cclkLine;
  logic [7:0] cfgData;
  logic [7:0] image [32];
  logic [7:0] expQ [$];
  int         err_count = 0, n_tests = 0, cycles = 0;
  integer     seed = 32'h31d9;

  always #5 clk = !clk;
  initial begin
    #7;
    forever #24 oscClk = !oscClk;
  end

  // Wired lines with pull-ups; clock pin pulled low when released
  assign initLine = (initStatusNOe ? initStatusNOut : 1'b1) & initHoldN;
  assign doneLine = (doneOe ? doneOut : 1'b1) & !extDoneLow;
  assign cclkLine = configClockOe ? configClockOut : 1'b0;

  msc_loader dut_u (.clk, .rst, .oscClk, .programRequestN, .modeSelectPins,
    .pullupDisablePin, .serialConfigIn, .configClockOut, .configClockOe,
    .serialConfigOut, .serialConfigOutOe, .initStatusNIn(initLine),
    .initStatusNOut, .initStatusNOe, .doneIn(doneLine), .doneOut, .doneOe,
    .userPullupEn, .userIoRelease, .cfgData, .cfgValid, .cfgReady,
    .configDone, .crcError, .modeError);

  msc_mem_model mem_u (.config_clock_out(cclkLine), .resetN(initLine),
    .selectN(doneLine), .image, .initHoldN, .dataOut(serialConfigIn));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    repeat (8) r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
    return r;
  endfunction

  // Payload compare against the oldest note, random stalls
  always @(posedge clk) begin
    if (!rst && cfgValid === 1'b1 && cfgReady) begin
      if (expQ.size() == 0) check(cfgData, ~cfgData);
      else check(cfgData, expQ.pop_front());
    end
    cfgReady <= #1 (($random(seed) & 3) != 0);
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic pulse_prog(input int n);
    @(posedge clk) #1 programRequestN = 1'b0;
    repeat (n) @(posedge clk);
    #1 programRequestN = 1'b1;
  endtask

  task automatic wait_end;
    int i;
    i = 0;
    while (i < 20000 && configDone !== 1'b1 && crcError !== 1'b1
           && modeError !== 1'b1 && doneOe !== 1'b0) begin
      @(posedge clk);
      i++;
    end
  endtask

  task automatic load(input logic [1:0] rate, input int n,
                      input logic [2:0] mode, input logic pull,
                      input logic bad, input logic chain);
    logic [7:0] c, b;
    c = 8'h00;
    image[0] = 8'ha5;
    image[1] = {6'h00, rate};
    image[2] = 8'h00;
    image[3] = 8'(n);
    for (int k = 0; k < n; k++) begin
      b = 8'($random(seed));
      image[4 + k] = b;
      c = crc8(c, b);
      if (mode == 3'h0) expQ.push_back(b);
    end
    image[4 + n] = bad ? ~c : c;
    // board pins steady, request high while loading
    @(posedge clk) #1 modeSelectPins = mode;
    pullupDisablePin = pull;
    extDoneLow = chain;
    pulse_prog(40);
    repeat (300) @(posedge clk);
    check(8'(userPullupEn), 8'(!pull));
    wait_end();
    if (chain) begin
      repeat (400) @(posedge clk);
      check(8'({configDone, serialConfigOutOe}), 8'h01);
      #1 extDoneLow = 1'b0;
    end
    repeat (10) @(posedge clk);
    if (mode != 3'h0) begin
      check(8'({modeError, configDone}), 8'h02);
    end else if (bad) begin
      check(8'({crcError, initStatusNOe, configDone}), 8'h06);
    end else begin
      check(8'({configDone, userIoRelease, configClockOe,
                serialConfigOutOe, doneOe, userPullupEn}), 8'h30);
      repeat (20) @(posedge clk);
      check(8'(expQ.size()), 8'h00);
    end
  endtask

  // Main sequence: every rate, chain wait, short pulse, faults
  initial begin
    for (int i = 0; i < 32; i++) image[i] = 8'h00;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    for (int r = 0; r < 4; r++) begin
      load(r[1:0], 2 + r, 3'h0, r[0], 1'b0, r == 2);
      if (r == 0) begin
        pulse_prog(20);
        repeat (50) @(posedge clk);
        check(8'(configDone), 8'h01);
      end
    end
    load(2'h1, 0, 3'h0, 1'b0, 1'b1, 1'b0);
    load(2'h0, 1, 3'h5, 1'b0, 1'b0, 1'b0);
    finish_test();
  end
endmodule // msc_loader_bench
